// ### include/asd_pkg.sv
`default_nettype none
package asd_pkg;
   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam int          ADDR_W         = 24;
   localparam logic [23:0] RESET_FETCH    = 24'hFF2080;
   localparam logic [23:0] CPU_SFR_LO     = 24'h000000;
   localparam logic [23:0] CPU_SFR_HI     = 24'h000017;
   localparam logic [23:0] SP_LO          = 24'h000018;
   localparam logic [23:0] SP_HI          = 24'h000019;
   localparam logic [23:0] LRF_HI         = 24'h0000FF;
   localparam logic [23:0] URF_LO         = 24'h000100;
   localparam logic [23:0] URF_HI         = 24'h0003FF;
   localparam logic [23:0] CDRAM_LO       = 24'h000400;
   localparam logic [23:0] CDRAM_HI       = 24'h0005FF;
   localparam logic [23:0] EXT0_HI        = 24'h001BFF;
   localparam logic [23:0] XRAM_LO        = 24'h001C00;
   localparam logic [23:0] XRAM_HI        = 24'h001DFF;
   localparam logic [23:0] NET_LO         = 24'h001E00;
   localparam logic [23:0] NET_HI         = 24'h001EFF;
   localparam logic [23:0] PSFR_LO        = 24'h001F00;
   localparam logic [23:0] PSFR_HI        = 24'h001FDF;
   localparam logic [23:0] MSFR_LO        = 24'h001FE0;
   localparam logic [23:0] MSFR_HI        = 24'h001FFF;
   localparam logic [23:0] REMAP_LO       = 24'h002000;
   localparam logic [23:0] REMAP_HI       = 24'h00FFFF;
   localparam logic [23:0] OVL_LO         = 24'h0F0000;
   localparam logic [23:0] OVL_HI         = 24'hFEFFFF;
   localparam logic [23:0] EMU_LO         = 24'hFF0000;
   localparam logic [23:0] EMU_HI         = 24'hFF00FF;
   localparam logic [23:0] HI_EXT0_HI     = 24'hFF03FF;
   localparam logic [23:0] HI_CDRAM_LO    = 24'hFF0400;
   localparam logic [23:0] HI_CDRAM_HI    = 24'hFF05FF;
   localparam logic [23:0] SPM_LO         = 24'hFF2000;
   localparam logic [23:0] SPM_HI         = 24'hFF207F;
   localparam logic [7:0]  WIN_BLOCKED_RD = 8'hFF;
   localparam logic [3:0]  MSG_BYTE_MASK  = 4'hF;
   localparam int          PIN_LINES_BIG  = 24;
   localparam int          PIN_LINES_SML  = 20;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ASD_RG_CPU_SFR, ASD_RG_STACK_PTR, ASD_RG_LOWER_RF, ASD_RG_UPPER_RF,
      ASD_RG_CODE_RAM, ASD_RG_XREG_RAM, ASD_RG_NET_SFR, ASD_RG_PERIPH_SFR,
      ASD_RG_MMAP_SFR, ASD_RG_OTP, ASD_RG_SPECIAL, ASD_RG_EMU,
      ASD_RG_OVERLAY, ASD_RG_EXTERNAL
   } asd_region_t;

   typedef enum logic [1:0] {
      ASD_AM_DIRECT, ASD_AM_INDIRECT, ASD_AM_EXTENDED, ASD_AM_WINDOW
   } asd_mode_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        fetch;
      asd_mode_t   mode;
      logic [23:0] addr;
   } asd_req_t;

   typedef struct packed {
      logic        valid;
      asd_region_t region;
      logic [13:0] sel;
      logic        allowed;
      logic        blocked_rd;
      logic        wr_suppress;
      logic [23:0] ext_addr;
      logic [3:0]  msg_index;
      logic [3:0]  msg_byte;
   } asd_resp_t;
endpackage
`default_nettype wire

// ### core/asd_onehot_enc.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Region to one-hot select, registered
// ------------------------------------------------------------
module asd_onehot_enc #(
   parameter int N = 14
) (
   input  wire logic                sys_clk_i,
   input  wire logic                reset_i,
   input  wire asd_pkg::asd_region_t region_i,
   output var  logic [N-1:0]        sel_o
);
   logic [N-1:0] sel_d;
   logic [N-1:0] sel_q;

   // One bit per region; a code past N-1 leaves every bit clear
   for (genvar g = 0; g < N; g++) begin : g_bit
      assign sel_d[g] = (int'(region_i) == g);
   end

   // Register so the select leaves a flip-flop
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sel_q <= '0;
      end else begin
         sel_q <= sel_d;
      end
   end

   assign sel_o = sel_q;
endmodule // asd_onehot_enc
`default_nettype wire

// ### core/asd_decoder.sv
// Operation
// - First fetch after reset from FF2080
// - 0000-0017 core registers, direct/indirect/indexed
// - 0018-0019 stack pointer, direct/indirect/indexed
// - 0000-00FF lower register file, all modes but window
// - 0100-03FF upper file, never plain direct
// - 1C00-1DFF register RAM, no plain direct
// - Code RAM at 0400 and FF0400 aliased
// - 2000-FFFF external or OTP by config bit
// - FF2000 special, FF2080 up program memory
// - 0F0000-FEFFFF external or overlay by package
// - 24 address lines large, 20 small
// - 1F00-1FDF peripherals, 1FE0-1FFF mapped
// - 1E00-1EFF network, 16-byte message objects
// - Listed gaps go to external bus
// - Windowed 1FE0-1FFF reads FF, writes ignored
`timescale 1ns/1ps
`default_nettype none
module asd_decoder #(
   parameter logic LARGE_PKG = 1'b1
) (
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   input  wire asd_pkg::asd_req_t req_i,
   input  wire logic              rom_remap_config_bit_i,
   output var  asd_pkg::asd_resp_t resp_o,
   output var  logic [23:0]       reset_vector_o
);
   // ------------------------------------------------------------
   // Combinational decode
   // ------------------------------------------------------------
   asd_pkg::asd_region_t region_d;
   asd_pkg::asd_resp_t   resp_d;
   asd_pkg::asd_resp_t   resp_q;
   logic [23:0]          a;
   logic [23:0]          pin_a;
   logic                 dir_ok;
   asd_pkg::asd_region_t enc_region;
   logic [13:0]          sel_w;

   // Priority by address; each address lands in one region
   always_comb begin
      // Decode the full address so the overlay range stays reachable;
      // only the pins see the narrower width on the small package
      a     = req_i.addr;
      pin_a = req_i.addr;
      if (!LARGE_PKG) begin
         pin_a[23:20] = {4{pin_a[19]}};
      end
      region_d = asd_pkg::ASD_RG_EXTERNAL;
      if (a <= asd_pkg::CPU_SFR_HI) begin
         region_d = asd_pkg::ASD_RG_CPU_SFR;
      end else if (a <= asd_pkg::SP_HI) begin
         region_d = asd_pkg::ASD_RG_STACK_PTR;
      end else if (a <= asd_pkg::LRF_HI) begin
         region_d = asd_pkg::ASD_RG_LOWER_RF;
      end else if (a <= asd_pkg::URF_HI) begin
         region_d = asd_pkg::ASD_RG_UPPER_RF;
      end else if (a <= asd_pkg::CDRAM_HI) begin
         region_d = asd_pkg::ASD_RG_CODE_RAM;
      end else if (a <= asd_pkg::EXT0_HI) begin
         region_d = asd_pkg::ASD_RG_EXTERNAL;
      end else if (a <= asd_pkg::XRAM_HI) begin
         region_d = asd_pkg::ASD_RG_XREG_RAM;
      end else if (a <= asd_pkg::NET_HI) begin
         region_d = asd_pkg::ASD_RG_NET_SFR;
      end else if (a <= asd_pkg::PSFR_HI) begin
         region_d = asd_pkg::ASD_RG_PERIPH_SFR;
      end else if (a <= asd_pkg::MSFR_HI) begin
         region_d = asd_pkg::ASD_RG_MMAP_SFR;
      end else if (a <= asd_pkg::REMAP_HI) begin
         region_d = rom_remap_config_bit_i ? asd_pkg::ASD_RG_OTP
                  : asd_pkg::ASD_RG_EXTERNAL;
      end else if (a >= asd_pkg::OVL_LO && a <= asd_pkg::OVL_HI) begin
         region_d = LARGE_PKG ? asd_pkg::ASD_RG_EXTERNAL
                  : asd_pkg::ASD_RG_OVERLAY;
      end else if (a >= asd_pkg::EMU_LO && a <= asd_pkg::EMU_HI) begin
         region_d = asd_pkg::ASD_RG_EMU;
      end else if (a >= asd_pkg::HI_CDRAM_LO && a <= asd_pkg::HI_CDRAM_HI) begin
         region_d = asd_pkg::ASD_RG_CODE_RAM;
      end else if (a >= asd_pkg::SPM_LO && a <= asd_pkg::SPM_HI) begin
         region_d = asd_pkg::ASD_RG_SPECIAL;
      end else if (a >= asd_pkg::RESET_FETCH) begin
         region_d = rom_remap_config_bit_i ? asd_pkg::ASD_RG_OTP
                  : asd_pkg::ASD_RG_EXTERNAL;
      end
   end

   // Mode check; plain direct only inside the lower file
   always_comb begin
      dir_ok = (region_d == asd_pkg::ASD_RG_CPU_SFR)
            || (region_d == asd_pkg::ASD_RG_STACK_PTR)
            || (region_d == asd_pkg::ASD_RG_LOWER_RF);
      resp_d             = '0;
      resp_d.valid       = req_i.valid;
      resp_d.region      = region_d;
      resp_d.ext_addr    = pin_a;
      resp_d.msg_index   = a[7:4];
      resp_d.msg_byte    = a[3:0] & asd_pkg::MSG_BYTE_MASK;
      case (req_i.mode)
         asd_pkg::ASD_AM_DIRECT:   resp_d.allowed = dir_ok;
         asd_pkg::ASD_AM_INDIRECT: resp_d.allowed = 1'b1;
         asd_pkg::ASD_AM_EXTENDED: resp_d.allowed =
            (region_d != asd_pkg::ASD_RG_UPPER_RF)
            && (region_d != asd_pkg::ASD_RG_XREG_RAM);
         asd_pkg::ASD_AM_WINDOW:   resp_d.allowed =
            (region_d == asd_pkg::ASD_RG_UPPER_RF)
            || (region_d == asd_pkg::ASD_RG_XREG_RAM)
            || (region_d == asd_pkg::ASD_RG_NET_SFR)
            || (region_d == asd_pkg::ASD_RG_PERIPH_SFR);
         default:                  resp_d.allowed = 1'b0;
      endcase
      // Mapped registers cannot be windowed: read FF, drop write
      if (req_i.mode == asd_pkg::ASD_AM_WINDOW
          && region_d == asd_pkg::ASD_RG_MMAP_SFR) begin
         resp_d.blocked_rd  = ~req_i.write;
         resp_d.wr_suppress = req_i.write;
      end
      if (!resp_d.allowed) begin
         resp_d.wr_suppress = req_i.write;
      end
   end

   // Response register
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         resp_q <= '0;
      end else begin
         resp_q <= resp_d;
      end
   end

   // Idle cycles feed an unused code, so the select flop clears itself
   // and the output needs no gate after the register
   assign enc_region = req_i.valid ? region_d
                     : asd_pkg::asd_region_t'('1);

   // Select bus, one hot
   asd_onehot_enc #(.N(14)) u_sel (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .region_i  (enc_region),
      .sel_o     (sel_w)
   );

   always_comb begin
      resp_o     = resp_q;
      resp_o.sel = sel_w;
   end

   // Reset vector held in a flop
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reset_vector_o <= asd_pkg::RESET_FETCH;
      end else begin
         reset_vector_o <= asd_pkg::RESET_FETCH;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   vector_fixed_a: assert property (reset_vector_o == 24'hFF2080)
      else $error("reset vector wrong");
   sp_region_a: assert property (req_i.valid && req_i.addr[23:1] == 23'h00000C
      |=> resp_o.region == asd_pkg::ASD_RG_STACK_PTR)
      else $error("stack pointer not decoded");
   upper_direct_a: assert property (req_i.valid
      && req_i.mode == asd_pkg::ASD_AM_DIRECT
      && req_i.addr >= 24'h000100 && req_i.addr <= 24'h0003FF
      |=> !resp_o.allowed)
      else $error("direct reached upper file");
   alias_ram_a: assert property (req_i.valid
      && req_i.addr >= 24'hFF0400 && req_i.addr <= 24'hFF05FF
      |=> resp_o.region == asd_pkg::ASD_RG_CODE_RAM)
      else $error("code RAM alias missing");
   remap_sel_a: assert property (req_i.valid && LARGE_PKG
      && req_i.addr >= 24'h002000 && req_i.addr <= 24'h00FFFF
      |=> resp_o.region == ($past(rom_remap_config_bit_i)
         ? asd_pkg::ASD_RG_OTP : asd_pkg::ASD_RG_EXTERNAL))
      else $error("remap wrong");
   window_block_a: assert property (req_i.valid && !req_i.write
      && req_i.mode == asd_pkg::ASD_AM_WINDOW
      && req_i.addr >= 24'h001FE0 && req_i.addr <= 24'h001FFF
      |=> resp_o.blocked_rd && !resp_o.wr_suppress)
      else $error("window read not blocked");
   onehot_sel_a: assert property (resp_o.valid |-> $onehot(resp_o.sel))
      else $error("select not one hot");
   net_index_a: assert property (req_i.valid
      && req_i.addr >= 24'h001E00 && req_i.addr <= 24'h001EFF
      |=> resp_o.region == asd_pkg::ASD_RG_NET_SFR
          && resp_o.msg_index == $past(req_i.addr[7:4]))
      else $error("network decode wrong");
endmodule // asd_decoder
`default_nettype wire

// ### verif/asd_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Core model: one request per cycle, driven just after an edge
// ------------------------------------------------------------
module asd_core_model (
   output var asd_pkg::asd_req_t req_o
);
   // Quiet request at time zero
   initial req_o = '0;

   // Emulator area is only ever written with its start value
   // Reserved areas see fill writes only, never reads
   task automatic send(input logic [23:0]        a,
                       input asd_pkg::asd_mode_t m,
                       input logic               w);
      req_o.valid = !(a[23:8] == 16'hFF00 && !w);
      req_o.write = w;
      req_o.fetch = 1'b0;
      req_o.mode  = m;
      req_o.addr  = a; // Whole words only, no byte lanes
   endtask

   // Released address flips so a stale value never looks valid
   task automatic idle();
      req_o.valid = 1'b0;
      req_o.addr  = ~req_o.addr;
   endtask
endmodule // asd_core_model
`default_nettype wire

// ### verif/tb_address_space_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_address_space_decoder;
   localparam asd_pkg::asd_mode_t D = asd_pkg::ASD_AM_DIRECT;
   localparam asd_pkg::asd_mode_t I = asd_pkg::ASD_AM_INDIRECT;
   localparam asd_pkg::asd_mode_t X = asd_pkg::ASD_AM_EXTENDED;
   localparam asd_pkg::asd_mode_t W = asd_pkg::ASD_AM_WINDOW;
   logic               sys_clk_i;
   logic               reset_i;
   logic               cfg;
   asd_pkg::asd_req_t  req;
   asd_pkg::asd_resp_t resp;
   asd_pkg::asd_resp_t resp_s;
   logic [23:0]        rvec;
   int                 n_fail;
   int                 n_compared;

   asd_core_model asd_core_model_i (.req_o(req));
   asd_decoder #(.LARGE_PKG(1'b1)) asd_decoder_i (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req),
      .rom_remap_config_bit_i(cfg), .resp_o(resp), .reset_vector_o(rvec));
   // Small package copy watches the same requests
   asd_decoder #(.LARGE_PKG(1'b0)) asd_decoder_small_i (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req),
      .rom_remap_config_bit_i(cfg), .resp_o(resp_s), .reset_vector_o());

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Back-to-back: caller sits just past an edge, answer one edge later
   task automatic acc(input logic [23:0] a, input asd_pkg::asd_mode_t m,
                      input logic w, input asd_pkg::asd_region_t rg,
                      input logic ok);
      logic blk;
      blk = (m == W) && (rg == asd_pkg::ASD_RG_MMAP_SFR) && !w;
      asd_core_model_i.send(a, m, w);
      @(posedge sys_clk_i);
      #1;
      cmp({20'h0, resp.region}, {20'h0, rg}, "region");
      cmp({10'h0, resp.sel}, 24'h1 << rg, "select");
      cmp({23'h0, resp.allowed}, {23'h0, ok}, "allowed");
      cmp({23'h0, resp.blocked_rd}, {23'h0, blk}, "read block");
      cmp({23'h0, resp.wr_suppress}, {23'h0, w & !ok}, "wr kill");
   endtask

   task automatic tally_and_finish();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_low();
      acc(24'h000000, D, 1'b0, asd_pkg::ASD_RG_CPU_SFR, 1'b1);
      acc(24'h000017, D, 1'b0, asd_pkg::ASD_RG_CPU_SFR, 1'b1);
      acc(24'h000018, D, 1'b0, asd_pkg::ASD_RG_STACK_PTR, 1'b1);
      acc(24'h000019, I, 1'b1, asd_pkg::ASD_RG_STACK_PTR, 1'b1);
      acc(24'h00001A, X, 1'b0, asd_pkg::ASD_RG_LOWER_RF, 1'b1);
      acc(24'h0000FF, D, 1'b1, asd_pkg::ASD_RG_LOWER_RF, 1'b1);
      $display("t_low done");
   endtask

   task automatic t_upper();
      acc(24'h000100, D, 1'b0, asd_pkg::ASD_RG_UPPER_RF, 1'b0);
      acc(24'h000200, D, 1'b1, asd_pkg::ASD_RG_UPPER_RF, 1'b0);
      acc(24'h0003FF, W, 1'b0, asd_pkg::ASD_RG_UPPER_RF, 1'b1);
      acc(24'h001C00, D, 1'b1, asd_pkg::ASD_RG_XREG_RAM, 1'b0);
      acc(24'h001DFF, I, 1'b0, asd_pkg::ASD_RG_XREG_RAM, 1'b1);
      $display("t_upper done");
   endtask

   task automatic t_ram();
      acc(24'h000400, X, 1'b1, asd_pkg::ASD_RG_CODE_RAM, 1'b1);
      acc(24'hFF05FF, I, 1'b0, asd_pkg::ASD_RG_CODE_RAM, 1'b1);
      acc(24'h000600, I, 1'b0, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      acc(24'h001BFF, X, 1'b1, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      acc(24'hFF0100, I, 1'b0, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      acc(24'hFF03FF, I, 1'b0, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      acc(24'hFF0400, I, 1'b0, asd_pkg::ASD_RG_CODE_RAM, 1'b1);
      acc(24'hFF1FFF, X, 1'b0, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      $display("t_ram done");
   endtask

   // Config bit changes between back-to-back requests
   task automatic t_remap();
      acc(24'h002000, I, 1'b0, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      acc(24'hFF2080, X, 1'b0, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      cfg = 1'b1;
      acc(24'h00FFFF, I, 1'b0, asd_pkg::ASD_RG_OTP, 1'b1);
      acc(24'hFF2080, X, 1'b0, asd_pkg::ASD_RG_OTP, 1'b1);
      acc(24'hFF207F, I, 1'b0, asd_pkg::ASD_RG_SPECIAL, 1'b1);
      cfg = 1'b0;
      acc(24'hFF2000, X, 1'b0, asd_pkg::ASD_RG_SPECIAL, 1'b1);
      $display("t_remap done");
   endtask

   task automatic t_sfr();
      acc(24'h001E00, W, 1'b0, asd_pkg::ASD_RG_NET_SFR, 1'b1);
      acc(24'h001EF6, I, 1'b0, asd_pkg::ASD_RG_NET_SFR, 1'b1);
      cmp({20'h0, resp.msg_index}, 24'hF, "msg object");
      cmp({20'h0, resp.msg_byte}, 24'h6, "msg byte");
      acc(24'h001F00, W, 1'b0, asd_pkg::ASD_RG_PERIPH_SFR, 1'b1);
      acc(24'h001FDF, X, 1'b1, asd_pkg::ASD_RG_PERIPH_SFR, 1'b1);
      acc(24'h001FE0, I, 1'b0, asd_pkg::ASD_RG_MMAP_SFR, 1'b1);
      acc(24'h001FFF, W, 1'b0, asd_pkg::ASD_RG_MMAP_SFR, 1'b0);
      acc(24'h001FE0, W, 1'b1, asd_pkg::ASD_RG_MMAP_SFR, 1'b0);
      $display("t_sfr done");
   endtask

   task automatic t_high();
      acc(24'h010000, I, 1'b0, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      acc(24'h0F0000, X, 1'b0, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      cmp(24'(resp_s.region), 24'(asd_pkg::ASD_RG_OVERLAY), "ovl");
      cmp(resp_s.ext_addr, 24'hFF0000, "20 lines");
      acc(24'hFEFFFF, I, 1'b1, asd_pkg::ASD_RG_EXTERNAL, 1'b1);
      cmp(resp.ext_addr, 24'hFEFFFF, "all 24 lines");
      acc(24'hFF0000, I, 1'b1, asd_pkg::ASD_RG_EMU, 1'b1);
      asd_core_model_i.idle();
      @(posedge sys_clk_i);
      #1;
      cmp({23'h0, resp.valid}, 24'h0, "idle");
      cmp({10'h0, resp.sel}, 24'h0, "idle select");
      $display("t_high done");
   endtask

   // ------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      n_fail = 0;
      n_compared = 0;
      reset_i = 1'b1;
      cfg = 1'b0;
      repeat (20) @(posedge sys_clk_i);
      #1;
      cmp({23'h0, resp.valid}, 24'h0, "reset valid");
      reset_i = 1'b0;
      cmp(rvec, 24'hFF2080, "first fetch");
      t_low();
      t_upper();
      t_ram();
      t_remap();
      t_sfr();
      t_high();
      tally_and_finish();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #20000;
      n_fail++;
      tally_and_finish();
   end
endmodule // tb_address_space_decoder
`default_nettype wire
